//--- design/pss_pkg.sv
// constants and types for the sensor spi command and response block
// Function
// - a write frame carries command nibble 1000 in its top bits and is decoded as a one-byte register write.
// - the register address field of a write frame selects the byte to be written.
// - the one data byte of a write frame is stored into the selected register.
// - a write is answered with command field 0100 followed by the basic health flags.
// - the write answer's upper data byte holds the odd byte of the addressed pair.
// - the write answer's lower data byte holds the even byte of the addressed pair.
// - sensor data request commands are accepted besides register access.
// - a sensor data answer is shifted out in the following frame, not the current one.
// - the answered measurement is the one present when select falls for the answering frame.
`default_nettype none
package pss_pkg;

	// ========================================================
	// frame layout
	localparam int          FRAME_BITS   = 32;
	localparam logic [5:0]  FRAME_BITS_C = 6'h20;
	localparam logic [3:0]  CMD_WRITE    = 4'h8;
	localparam logic [3:0]  RSP_WRITE    = 4'h4;
	localparam logic [3:0]  RSP_ERROR    = 4'h0;
	localparam logic [1:0]  ERR_HEALTH   = 2'h3;
	localparam int          CMD_SENS_BIT = 28;

	// ========================================================
	// check byte generator, msb first
	localparam logic [7:0]  CRC_POLY     = 8'h2f;
	localparam logic [7:0]  CRC_SEED     = 8'hff;

	// ========================================================
	// types
	typedef struct packed {
		logic [3:0] cmd;
		logic [3:0] fixed;
		logic [7:0] addr;
		logic [7:0] data;
		logic [7:0] crc;
	} pss_cmd_frame_t;

	typedef struct packed {
		logic [11:0] sample;
		logic [1:0]  health;
		logic [1:0]  detail;
	} pss_sensor_t;

	typedef enum logic [1:0] {
		PEND_NONE  = 2'b00,
		PEND_WRITE = 2'b01,
		PEND_SENS  = 2'b11,
		PEND_ERR   = 2'b10
	} pss_pend_t;

endpackage
`default_nettype wire

//--- design/pss_crc8.sv
// eight-bit check byte over the upper 24 bits of a frame
`timescale 1ns/1ps
`default_nettype none
module pss_crc8 (
	input  wire logic [23:0] data,
	output logic      [7:0]  crc
);
	always_comb begin
		logic fb;
		fb  = 1'b0;
		crc = pss_pkg::CRC_SEED;
		for (int i = 23; i >= 0; i--) begin
			fb  = crc[7] ^ data[i];
			crc = {crc[6:0], 1'b0} ^ (fb ? pss_pkg::CRC_POLY : 8'h00);
		end
	end
endmodule
`default_nettype wire

//--- design/pss_spi_core.sv
// spi frame decoder and response framer with byte register store
`timescale 1ns/1ps
`default_nettype none
module pss_spi_core (
	input  wire logic                 core_clk,
	input  wire logic                 reset_n,
	input  wire logic                 spi_sclk,
	input  wire logic                 spi_ss_b,
	input  wire logic                 spi_mosi,
	output logic                      spi_miso,
	output logic                      spi_miso_oe_n,
	input  wire pss_pkg::pss_sensor_t sensor_in
);
	// ========================================================
	// storage and state
	logic [7:0]          regs [256];
	logic                sclk_prev_reg, sclk_prev_next;
	logic                ss_prev_reg,   ss_prev_next;
	logic [31:0]         rx_reg,        rx_next;
	logic [31:0]         tx_reg,        tx_next;
	logic [5:0]          cnt_reg,       cnt_next;
	logic                miso_reg,      miso_next;
	logic                oe_n_reg,      oe_n_next;
	pss_pkg::pss_pend_t  pend_reg,      pend_next;
	logic [7:0]          paddr_reg,     paddr_next;
	logic [3:0]          pcmd_reg,      pcmd_next;
	logic                we;
	pss_pkg::pss_cmd_frame_t cf;
	logic                sclk_rise, sclk_fall, ss_fall, ss_rise;
	logic                frame_ok, crc_ok, is_write, is_sens;
	logic [23:0]         rsp_body;
	logic [7:0]          rsp_crc, rx_crc;
	logic [7:0]          pair_hi, pair_lo;

	assign sclk_rise = spi_sclk & ~sclk_prev_reg;
	assign sclk_fall = ~spi_sclk & sclk_prev_reg;
	assign ss_fall   = ss_prev_reg & ~spi_ss_b;
	assign ss_rise   = ~ss_prev_reg & spi_ss_b;
	assign cf        = pss_pkg::pss_cmd_frame_t'(rx_reg);
	assign pair_hi   = regs[{paddr_reg[7:1], 1'b1}];
	assign pair_lo   = regs[{paddr_reg[7:1], 1'b0}];

	pss_crc8 u_rx_crc (
		.data (rx_reg[31:8]),
		.crc  (rx_crc)
	);
	pss_crc8 u_tx_crc (
		.data (rsp_body),
		.crc  (rsp_crc)
	);

	// ========================================================
	// command decode at end of frame
	always_comb begin
		frame_ok = (cnt_reg == pss_pkg::FRAME_BITS_C);
		crc_ok   = (rx_crc == cf.crc);
		is_write = (cf.cmd == pss_pkg::CMD_WRITE);
		is_sens  = rx_reg[pss_pkg::CMD_SENS_BIT];
		we       = ss_rise & frame_ok & crc_ok & is_write;
	end

	// ========================================================
	// response body chosen by the pending answer
	always_comb begin
		unique case (pend_reg)
			pss_pkg::PEND_WRITE: rsp_body = {pss_pkg::RSP_WRITE,
				sensor_in.health, 2'b00, pair_hi, pair_lo};
			pss_pkg::PEND_SENS:  rsp_body = {pcmd_reg,
				sensor_in.health, sensor_in.sample,
				4'h0, sensor_in.detail};
			pss_pkg::PEND_ERR:   rsp_body = {pss_pkg::RSP_ERROR,
				pss_pkg::ERR_HEALTH, 18'h00000};
			pss_pkg::PEND_NONE:  rsp_body = 24'h000000;
		endcase
	end

	// ========================================================
	// shifter and frame sequencing
	always_comb begin
		sclk_prev_next = spi_sclk;
		ss_prev_next   = spi_ss_b;
		rx_next        = rx_reg;
		tx_next        = tx_reg;
		cnt_next       = cnt_reg;
		miso_next      = miso_reg;
		oe_n_next      = spi_ss_b;
		pend_next      = pend_reg;
		paddr_next     = paddr_reg;
		pcmd_next      = pcmd_reg;
		if (ss_fall) begin
			// answer of the last frame goes out now
			tx_next   = {rsp_body, rsp_crc};
			miso_next = rsp_body[23];
			cnt_next  = 6'h00;
		end else if (!spi_ss_b) begin
			if (sclk_rise && cnt_reg != pss_pkg::FRAME_BITS_C) begin
				rx_next  = {rx_reg[30:0], spi_mosi};
				cnt_next = cnt_reg + 6'h01;
			end
			if (sclk_fall) begin
				tx_next   = {tx_reg[30:0], 1'b0};
				miso_next = tx_reg[30];
			end
		end
		if (ss_rise) begin
			miso_next = 1'b0;
			if (!frame_ok || !crc_ok) begin
				pend_next = pss_pkg::PEND_ERR;
			end else if (is_write) begin
				pend_next  = pss_pkg::PEND_WRITE;
				paddr_next = cf.addr;
			end else if (is_sens) begin
				pend_next = pss_pkg::PEND_SENS;
				pcmd_next = cf.cmd;
			end else begin
				// reserved codes fall outside this block
				pend_next = pss_pkg::PEND_ERR;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			sclk_prev_reg <= 1'b0;
			ss_prev_reg   <= 1'b1;
			rx_reg        <= 32'h00000000;
			tx_reg        <= 32'h00000000;
			cnt_reg       <= 6'h00;
			miso_reg      <= 1'b0;
			oe_n_reg      <= 1'b1;
			pend_reg      <= pss_pkg::PEND_NONE;
			paddr_reg     <= 8'h00;
			pcmd_reg      <= 4'h0;
		end else begin
			sclk_prev_reg <= sclk_prev_next;
			ss_prev_reg   <= ss_prev_next;
			rx_reg        <= rx_next;
			tx_reg        <= tx_next;
			cnt_reg       <= cnt_next;
			miso_reg      <= miso_next;
			oe_n_reg      <= oe_n_next;
			pend_reg      <= pend_next;
			paddr_reg     <= paddr_next;
			pcmd_reg      <= pcmd_next;
		end
	end

	// write lands only once the carrying frame has closed
	// cleared at reset so an unwritten byte of a pair answer reads as 00
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			for (int i = 0; i < 256; i++) begin
				regs[i] <= 8'h00;
			end
		end else if (we) begin
			regs[cf.addr] <= cf.data;
		end
	end

	assign spi_miso      = miso_reg;
	assign spi_miso_oe_n = oe_n_reg;

	// ========================================================
	// checks
	property p_write_store;
		@(posedge core_clk) disable iff (!reset_n)
		we |=> regs[$past(cf.addr)] == $past(cf.data);
	endproperty
	a_write_store: assert property (p_write_store)
		else $error("write data not stored");

	property p_write_decode;
		@(posedge core_clk) disable iff (!reset_n)
		(ss_rise && frame_ok && crc_ok && cf.cmd == 4'h8)
		|=> pend_reg == pss_pkg::PEND_WRITE && paddr_reg == $past(cf.addr);
	endproperty
	a_write_decode: assert property (p_write_decode)
		else $error("write command not decoded");

	property p_write_rsp_cmd;
		@(posedge core_clk) disable iff (!reset_n)
		(ss_fall && pend_reg == pss_pkg::PEND_WRITE)
		|=> tx_reg[31:26] == {4'h4, $past(sensor_in.health)};
	endproperty
	a_write_rsp_cmd: assert property (p_write_rsp_cmd)
		else $error("write answer header wrong");

	property p_write_rsp_hi;
		@(posedge core_clk) disable iff (!reset_n)
		(ss_fall && pend_reg == pss_pkg::PEND_WRITE)
		|=> tx_reg[23:16] == regs[{paddr_reg[7:1], 1'b1}];
	endproperty
	a_write_rsp_hi: assert property (p_write_rsp_hi)
		else $error("write answer high byte wrong");

	property p_write_rsp_lo;
		@(posedge core_clk) disable iff (!reset_n)
		(ss_fall && pend_reg == pss_pkg::PEND_WRITE)
		|=> tx_reg[15:8] == regs[{paddr_reg[7:1], 1'b0}];
	endproperty
	a_write_rsp_lo: assert property (p_write_rsp_lo)
		else $error("write answer low byte wrong");

	property p_sens_accept;
		@(posedge core_clk) disable iff (!reset_n)
		(ss_rise && frame_ok && crc_ok && rx_reg[28])
		|=> pend_reg == pss_pkg::PEND_SENS && pcmd_reg == $past(cf.cmd);
	endproperty
	a_sens_accept: assert property (p_sens_accept)
		else $error("sensor request not accepted");

	property p_sens_next_frame;
		@(posedge core_clk) disable iff (!reset_n)
		(ss_fall && pend_reg == pss_pkg::PEND_SENS)
		|=> tx_reg[31:28] == pcmd_reg ##1 spi_miso == tx_reg[31];
	endproperty
	a_sens_next_frame: assert property (p_sens_next_frame)
		else $error("sensor answer not sent in next frame");

	property p_sens_sample;
		@(posedge core_clk) disable iff (!reset_n)
		(ss_fall && pend_reg == pss_pkg::PEND_SENS)
		|=> tx_reg[25:14] == $past(sensor_in.sample);
	endproperty
	a_sens_sample: assert property (p_sens_sample)
		else $error("sensor sample not taken at select fall");

	property p_bad_check;
		@(posedge core_clk) disable iff (!reset_n)
		(ss_rise && rx_crc != cf.crc) |=> pend_reg == pss_pkg::PEND_ERR;
	endproperty
	a_bad_check: assert property (p_bad_check)
		else $error("bad check byte not refused");

	c_write: cover property (@(posedge core_clk) disable iff (!reset_n) we);
	c_sens:  cover property (@(posedge core_clk) disable iff (!reset_n)
		ss_fall && pend_reg == pss_pkg::PEND_SENS);
	c_err:   cover property (@(posedge core_clk) disable iff (!reset_n)
		ss_fall && pend_reg == pss_pkg::PEND_ERR);
endmodule
`default_nettype wire

//--- verification/pss_host_model.sv
// spi host model: one 32-bit mode 0 frame per select period
`timescale 1ns/1ps
`default_nettype none
module pss_host_model (
	input  wire logic core_clk,
	output logic      spi_sclk,
	output logic      spi_ss_b,
	output logic      spi_mosi,
	input  wire logic spi_miso
);
	// ========================================
	// idle levels
	initial begin
		spi_sclk = 1'b0;
		spi_ss_b = 1'b1;
		spi_mosi = 1'b1;
	end

	// ========================================
	// frame transfer, msb first
	// slow edges: the device detects sclk by sampling on core_clk
	task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
		rx = 32'h0;
		@(posedge core_clk);
		spi_ss_b <= 1'b0;
		spi_mosi <= tx[31];
		repeat (4) @(posedge core_clk);
		for (int i = 31; i >= 0; i--) begin
			spi_sclk <= 1'b1;
			@(posedge core_clk);
			rx = {rx[30:0], spi_miso};
			@(posedge core_clk);
			spi_sclk <= 1'b0;
			if (i > 0) spi_mosi <= tx[i-1];
			repeat (3) @(posedge core_clk);
		end
		spi_ss_b <= 1'b1;
		// released line must not keep showing the last bit
		spi_mosi <= ~spi_mosi;
		repeat (3) @(posedge core_clk);
	endtask
endmodule
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the sensor spi command block
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [1:0] health_c = 2'h2;
	logic                 core_clk;
	logic                 reset_n;
	logic                 spi_sclk;
	logic                 spi_ss_b;
	logic                 spi_mosi;
	logic                 spi_miso;
	logic                 spi_miso_oe_n;
	pss_pkg::pss_sensor_t sensor_in;
	int                   err_count;
	int                   compares;
	logic [31:0]          rx;

	pss_spi_core i_pss_spi_core (.core_clk(core_clk), .reset_n(reset_n),
		.spi_sclk(spi_sclk), .spi_ss_b(spi_ss_b), .spi_mosi(spi_mosi),
		.spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n),
		.sensor_in(sensor_in));
	pss_host_model i_pss_host_model (.core_clk(core_clk),
		.spi_sclk(spi_sclk), .spi_ss_b(spi_ss_b), .spi_mosi(spi_mosi),
		.spi_miso(spi_miso));

	initial core_clk = 1'b0;
	always #12.5 core_clk = ~core_clk;

	// ========================================
	// frame builders
	function automatic logic [31:0] frm(input logic [23:0] d);
		logic [7:0] c;
		c = pss_pkg::CRC_SEED;
		for (int i = 23; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? pss_pkg::CRC_POLY : 8'h00);
		return {d, c};
	endfunction
	function automatic logic [31:0] wr(input logic [7:0] a, input logic [7:0] d);
		return frm({pss_pkg::CMD_WRITE, 4'h0, a, d});
	endfunction
	function automatic logic [31:0] wa(input logic [7:0] hi, input logic [7:0] lo);
		return frm({pss_pkg::RSP_WRITE, health_c, 2'h0, hi, lo});
	endfunction
	function automatic logic [31:0] sreq(input logic [3:0] c);
		return frm({c, 20'h0});
	endfunction
	function automatic logic [31:0] sens(input logic [3:0] c,
		input pss_pkg::pss_sensor_t s);
		return frm({c, s.health, s.sample, 4'h0, s.detail});
	endfunction

	// ========================================
	// checking and verdict
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ========================================
	// scenarios
	task automatic t_write;
		check("idle oe_n", {31'h0, spi_miso_oe_n}, 32'h1);
		i_pss_host_model.xfer(wr(8'h10, 8'ha5), rx);
		check("reset answer", rx, frm(24'h000000));
		i_pss_host_model.xfer(wr(8'h11, 8'h3c), rx);
		check("write code", {28'h0, rx[31:28]}, 32'h4);
		check("first pair", rx, wa(8'h00, 8'ha5));
		i_pss_host_model.xfer(wr(8'h10, 8'h5a), rx);
		check("write pair", rx, wa(8'h3c, 8'ha5));
		i_pss_host_model.xfer(sreq(4'h1), rx);
		check("rewrite pair", rx, wa(8'h3c, 8'h5a));
		$display("t_write done");
	endtask

	task automatic t_badcrc;
		// flipped check byte: write must be dropped
		i_pss_host_model.xfer(wr(8'h10, 8'h00) ^ 32'hff, rx);
		check("sens answer", rx, sens(4'h1, sensor_in));
		i_pss_host_model.xfer(wr(8'h11, 8'hc3), rx);
		check("err answer", rx, frm({pss_pkg::RSP_ERROR,
			pss_pkg::ERR_HEALTH, 18'h0}));
		i_pss_host_model.xfer(sreq(4'h3), rx);
		check("pair kept", rx, wa(8'hc3, 8'h5a));
		$display("t_badcrc done");
	endtask

	task automatic t_sensor;
		logic [3:0]           prev;
		pss_pkg::pss_sensor_t v;
		prev = 4'h3;
		for (int k = 0; k < 9; k++) begin
			v = {8'ha5, k[3:0], health_c, k[1:0]};
			@(posedge core_clk);
			sensor_in <= v;
			fork
				i_pss_host_model.xfer(sreq({k[2:0], 1'b1}), rx);
				begin
					repeat (40) @(posedge core_clk);
					check("busy oe_n", {31'h0, spi_miso_oe_n}, 32'h0);
					sensor_in <= {12'hfff, health_c, 2'h3};
				end
			join
			check("sens data", rx, sens(prev, v));
			prev = {k[2:0], 1'b1};
		end
		$display("t_sensor done");
	endtask

	task automatic t_reserved;
		// even code other than a write earns the error answer
		i_pss_host_model.xfer(frm({4'h2, 20'h0}), rx);
		check("last sens", rx, sens(4'h1, sensor_in));
		i_pss_host_model.xfer(sreq(4'h5), rx);
		check("reserved answer", rx, frm({pss_pkg::RSP_ERROR,
			pss_pkg::ERR_HEALTH, 18'h0}));
		$display("t_reserved done");
	endtask

	// ========================================
	// main sequence and watchdog
	initial begin
		reset_n = 1'b0;
		sensor_in = {12'h000, health_c, 2'h0};
		err_count = 0;
		compares = 0;
		repeat (16) @(posedge core_clk);
		reset_n <= 1'b1;
		t_write;
		t_badcrc;
		t_sensor;
		t_reserved;
		tally_and_finish;
	end
	// about 18 frames of 170 cycles; generous margin
	initial begin
		repeat (10000) @(posedge core_clk);
		err_count++;
		$display("ERROR watchdog expected done seen timeout");
		tally_and_finish;
	end
endmodule
`default_nettype wire
